/* File: design/prd_clock_core.sv */
// Reference divider, input steering, phase detector and output dividers
//
// Notes on behaviour
// - Reference input divided by a fourteen-bit counter with programmable terminal count.
// - Any divide value from 1 to 16383 divides by exactly that.
// - Divide value zero acts as divide by one.
// - Upper six bits in one register, lower eight in the next.
// - Divided reference drives one phase detector input.
// - Source select zero feeds the second input to the output dividers.
// - After reset the first input feeds the output dividers.
// - Only the second input reaches the feedback path.
// - Each output divider divides by any integer from 1 to 32.
// - Each output divider has programmable duty cycle and phase start.
// - Without the loop either input can be steered to the outputs.
// - Loop section can be switched off while outputs keep running.
// - Pump pulses steer the undivided oscillator feedback to reference over divide.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module prd_clock_core (
  input wire logic clk_in,
  input wire logic rst_in,
  input prd_pkg::prd_axi_req_t axi_in,
  output prd_pkg::prd_axi_rsp_t axi_out,
  input wire logic reference_input_in,
  input wire logic reference_input_complement_in,
  input wire logic distribution_clock_input_in,
  input wire logic oscillator_feedback_input_in,
  output logic pfd_ref_out,
  output logic pfd_fb_out,
  output logic pump_up_out,
  output logic pump_down_out,
  output logic [prd_pkg::OUT_CNT-1:0] dist_clk_out
);
  import prd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [PIN_CNT-1:0] pin_s1;
  logic [PIN_CNT-1:0] pin_s2;
  logic [PIN_CNT-1:0] pin_s3;
  logic [REF_UPPER_W-1:0] ref_upper;
  logic [REF_LOWER_W-1:0] ref_lower;
  logic src_sel;
  logic pll_on;
  prd_div_cfg_t div_cfg [OUT_CNT];
  logic [OUT_CNT-1:0] div_load;
  logic aw_held;
  logic w_held;
  logic [IDX_W-1:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [REF_DIV_W-1:0] ref_cnt;
  logic ref_pulse;
  logic fb_pulse;
  logic pump_up;
  logic pump_down;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers on every pin, third flop for edges
  wire [PIN_CNT-1:0] pin_raw = {oscillator_feedback_input_in, distribution_clock_input_in,
    reference_input_complement_in, reference_input_in};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Differential reference and rising edges
  wire ref_level = pin_s2[PIN_REF] & ~pin_s2[PIN_REFC];
  wire ref_level_d = pin_s3[PIN_REF] & ~pin_s3[PIN_REFC];
  wire ref_edge = ref_level & ~ref_level_d;
  wire [PIN_CNT-1:0] pin_rise = pin_s2 & ~pin_s3;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel decode
  wire aw_take = axi_in.awvalid & ~aw_held;
  wire w_take = axi_in.wvalid & ~w_held;
  wire wr_fire = aw_held & w_held & ~bvalid_q;
  wire hit_upper_w = aw_idx == IDX_REF_UPPER;
  wire hit_lower_w = aw_idx == IDX_REF_LOWER;
  wire hit_sel_w = aw_idx == IDX_SRC_SEL;
  wire hit_pll_w = aw_idx == IDX_PLL_CTRL;
  wire hit_div_w = (aw_idx >= IDX_DIV_BASE) && (aw_idx <= IDX_DIV_LAST);
  wire wr_mapped = hit_upper_w | hit_lower_w | hit_sel_w | hit_pll_w | hit_div_w;
  wire [2:0] div_sel_w = aw_idx[2:0];
  wire ref_reload = wr_fire & (hit_upper_w | hit_lower_w) & w_strb[0];

  // Address and data holding, taken in either order
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_held <= 1'b0;
      aw_idx <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_idx <= axi_in.awaddr[AXI_AW-1:2];
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= axi_in.wdata;
      w_strb <= axi_in.wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_in.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ref_upper <= RST_REF_UPPER;
      ref_lower <= RST_REF_LOWER;
      src_sel <= RST_SRC_SEL;
      pll_on <= RST_PLL_ON;
    end else if (wr_fire && w_strb[0]) begin
      if (hit_upper_w) ref_upper <= w_data[REF_UPPER_W-1:0];
      if (hit_lower_w) ref_lower <= w_data[REF_LOWER_W-1:0];
      if (hit_sel_w) src_sel <= w_data[SRC_SEL_BIT];
      if (hit_pll_w) pll_on <= w_data[PLL_ON_BIT];
    end
  end

  // Steered source for the output dividers, either input
  wire dist_level = src_sel ? pin_s2[PIN_DIST] : pin_s2[PIN_OSC];
  wire dist_edge = src_sel ? pin_rise[PIN_DIST] : pin_rise[PIN_OSC];

  // Output divider settings, one byte lane per field
  genvar g;
  generate
    for (g = 0; g < OUT_CNT; g++) begin : gen_out
      wire wr_this = wr_fire & hit_div_w & (div_sel_w == 3'(g));
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          div_cfg[g] <= '{RST_DIV_FIELD, RST_DIV_FIELD, RST_DIV_FIELD};
          div_load[g] <= 1'b0;
        end else begin
          div_load[g] <= wr_this;
          if (wr_this && w_strb[0]) div_cfg[g].ratio_m1 <= w_data[DIVCFG_RATIO_LSB +: DIV_W];
          if (wr_this && w_strb[1]) div_cfg[g].high_m1 <= w_data[DIVCFG_HIGH_LSB +: DIV_W];
          if (wr_this && w_strb[2]) div_cfg[g].phase <= w_data[DIVCFG_PHASE_LSB +: DIV_W];
        end
      end
      // Each output runs from the steered source, independent of the loop
      prd_out_divider u_div (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .src_edge_in(dist_edge),
        .src_level_in(dist_level),
        .cfg_in(div_cfg[g]),
        .load_in(div_load[g]),
        .clk_out(dist_clk_out[g]),
        .tick_out()
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  wire ar_take = axi_in.arvalid & ~rvalid_q;
  wire [IDX_W-1:0] ar_idx = axi_in.araddr[AXI_AW-1:2];
  wire hit_div_r = (ar_idx >= IDX_DIV_BASE) && (ar_idx <= IDX_DIV_LAST);
  wire [2:0] div_sel_r = ar_idx[2:0];
  wire [31:0] div_word = {11'h000, div_cfg[div_sel_r].phase, 3'h0, div_cfg[div_sel_r].high_m1,
    3'h0, div_cfg[div_sel_r].ratio_m1};
  wire [31:0] stat_word = {2'h0, ref_cnt, dist_clk_out, 4'h0, pump_down, pump_up, pll_on, src_sel};
  wire rd_hit = (ar_idx == IDX_REF_UPPER) | (ar_idx == IDX_REF_LOWER) | (ar_idx == IDX_SRC_SEL) |
    (ar_idx == IDX_PLL_CTRL) | (ar_idx == IDX_STATUS) | hit_div_r;
  wire [31:0] rd_word =
    (ar_idx == IDX_REF_UPPER) ? {26'h000_0000, ref_upper} :
    (ar_idx == IDX_REF_LOWER) ? {24'h00_0000, ref_lower} :
    (ar_idx == IDX_SRC_SEL) ? {31'h0000_0000, src_sel} :
    (ar_idx == IDX_PLL_CTRL) ? {31'h0000_0000, pll_on} :
    (ar_idx == IDX_STATUS) ? stat_word :
    hit_div_r ? div_word : 32'h0000_0000;

  // Read data is caught on the address edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_in.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Bus answer
  assign axi_out = '{awready: ~aw_held, wready: ~w_held, bvalid: bvalid_q, bresp: bresp_q,
    arready: ~rvalid_q, rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};

  ////////////////////////////////////////////////////////////////////////////
  // Reference divider
  wire [REF_DIV_W-1:0] ref_div = {ref_upper, ref_lower};
  wire [REF_DIV_W-1:0] ref_term = (ref_div == REF_DIV_ZERO) ? REF_DIV_ONE : ref_div;
  wire ref_wrap = ref_cnt >= ref_term - REF_DIV_ONE;

  // Counts reference edges, pulses and reloads at terminal count
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ref_cnt <= REF_DIV_ZERO;
      ref_pulse <= 1'b0;
    end else if (!pll_on || ref_reload) begin
      ref_cnt <= REF_DIV_ZERO;
      ref_pulse <= 1'b0;
    end else begin
      ref_pulse <= ref_edge & ref_wrap;
      if (ref_edge) ref_cnt <= ref_wrap ? REF_DIV_ZERO : ref_cnt + REF_DIV_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase detector: first arrival raises its pump, both clear together
  wire up_any = pump_up | ref_pulse;
  wire dn_any = pump_down | fb_pulse;
  wire pfd_clear = up_any & dn_any;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fb_pulse <= 1'b0;
      pump_up <= 1'b0;
      pump_down <= 1'b0;
    end else begin
      fb_pulse <= pll_on & pin_rise[PIN_OSC];
      pump_up <= pll_on & up_any & ~pfd_clear;
      pump_down <= pll_on & dn_any & ~pfd_clear;
    end
  end

  assign pfd_ref_out = ref_pulse;
  assign pfd_fb_out = fb_pulse;
  assign pump_up_out = pump_up;
  assign pump_down_out = pump_down;

  ////////////////////////////////////////////////////////////////////////////
  // Edges since the last reference pulse, for checking only
  logic [REF_DIV_W:0] ref_edges;
  logic ref_seen;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ref_edges <= '0;
      ref_seen <= 1'b0;
    end else if (!pll_on || ref_reload) begin
      ref_edges <= '0;
      ref_seen <= 1'b0;
    end else if (ref_pulse) begin
      ref_edges <= {{REF_DIV_W{1'b0}}, ref_edge};
      ref_seen <= 1'b1;
    end else if (ref_edge) begin
      ref_edges <= ref_edges + 1'b1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  ref_period_a: assert property (
    (ref_pulse && ref_seen) |-> ref_edges == {1'b0, ref_term})
    else $error("reference pulse spacing differs from divide value");

  ref_zero_one_a: assert property (
    (pll_on && !ref_reload && ref_div == REF_DIV_ZERO && ref_edge) |=> ref_pulse)
    else $error("zero divide value did not pass each reference edge");

  ref_count_cap_a: assert property (
    ref_cnt < ref_term)
    else $error("reference counter passed its terminal count");

  ref_split_a: assert property (
    (wr_fire && hit_upper_w && w_strb[0]) |=> ref_div[13:8] == $past(w_data[5:0]))
    else $error("upper divide bits not taken from low field");

  pfd_route_a: assert property (
    (pll_on && ref_pulse && !pump_up && !pump_down && !fb_pulse) |=> pump_up_out && !pump_down_out)
    else $error("divided reference did not reach phase detector");

  src_select_a: assert property (
    (!src_sel && pin_rise[PIN_DIST] && !pin_rise[PIN_OSC]) |-> !dist_edge)
    else $error("first input reached outputs while second selected");

  sel_reset_a: assert property (
    $past(rst_in) |-> src_sel)
    else $error("first input not selected after reset");

  fb_only_osc_a: assert property (
    (pin_rise[PIN_DIST] && !pin_rise[PIN_OSC]) |=> !pfd_fb_out)
    else $error("first input reached the feedback path");

  pll_off_a: assert property (
    !pll_on |=> !pfd_ref_out && !pump_up_out && !pump_down_out)
    else $error("loop section active while switched off");

  pump_excl_a: assert property (
    !(pump_up_out && pump_down_out))
    else $error("both pump outputs high together");

  ref_div_c: cover property (ref_pulse && ref_seen && ref_div > REF_DIV_ONE);
  second_src_c: cover property (!src_sel && dist_edge);
  pump_down_c: cover property (pump_down_out);
  pll_off_c: cover property (!pll_on && dist_edge);

endmodule

/* File: include/prd_pkg.sv */
// Constants, layouts and carrier types for the reference divider and clock steering block
package prd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and counts
  localparam int REF_DIV_W = 14;
  localparam int REF_UPPER_W = 6;
  localparam int REF_LOWER_W = 8;
  localparam int DIV_W = 5;
  localparam int OUT_CNT = 8;
  localparam int AXI_AW = 12;
  localparam int IDX_W = 10;

  // Pin positions in the synchroniser vector
  localparam int PIN_CNT = 4;
  localparam int PIN_REF = 0;
  localparam int PIN_REFC = 1;
  localparam int PIN_DIST = 2;
  localparam int PIN_OSC = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_REF_UPPER = 10'h00b;
  localparam logic [IDX_W-1:0] IDX_REF_LOWER = 10'h00c;
  localparam logic [IDX_W-1:0] IDX_SRC_SEL = 10'h045;
  localparam logic [IDX_W-1:0] IDX_DIV_BASE = 10'h048;
  localparam logic [IDX_W-1:0] IDX_DIV_LAST = 10'h04f;
  localparam logic [IDX_W-1:0] IDX_PLL_CTRL = 10'h050;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h051;

  // Field positions
  localparam int SRC_SEL_BIT = 0;
  localparam int PLL_ON_BIT = 0;
  localparam int DIVCFG_RATIO_LSB = 0;
  localparam int DIVCFG_HIGH_LSB = 8;
  localparam int DIVCFG_PHASE_LSB = 16;

  // Reset values
  localparam logic [REF_UPPER_W-1:0] RST_REF_UPPER = 6'h00;
  localparam logic [REF_LOWER_W-1:0] RST_REF_LOWER = 8'h00;
  localparam logic RST_SRC_SEL = 1'b1;
  localparam logic RST_PLL_ON = 1'b1;
  localparam logic [DIV_W-1:0] RST_DIV_FIELD = 5'h00;

  // Divider constants
  localparam logic [REF_DIV_W-1:0] REF_DIV_ZERO = 14'h0000;
  localparam logic [REF_DIV_W-1:0] REF_DIV_ONE = 14'h0001;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_AW-1:0] araddr;
    logic rready;
  } prd_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } prd_axi_rsp_t;

  typedef struct packed {
    logic [DIV_W-1:0] phase;
    logic [DIV_W-1:0] high_m1;
    logic [DIV_W-1:0] ratio_m1;
  } prd_div_cfg_t;

endpackage

/* File: design/prd_out_divider.sv */
// One distribution output divider with duty cycle and phase start
`timescale 1ns/1ps
module prd_out_divider (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic src_edge_in,
  input wire logic src_level_in,
  input prd_pkg::prd_div_cfg_t cfg_in,
  input wire logic load_in,
  output logic clk_out,
  output logic tick_out
);
  import prd_pkg::*;

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic [DIV_W:0] edge_seen;
  logic period_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Count decode
  wire wrap = cnt >= cfg_in.ratio_m1;
  wire bypass = cfg_in.ratio_m1 == RST_DIV_FIELD;
  wire [DIV_W-1:0] phase_start = (cfg_in.phase > cfg_in.ratio_m1) ? RST_DIV_FIELD : cfg_in.phase;
  // Reload on new setting, else step per source edge
  assign next_cnt = load_in ? phase_start :
    (src_edge_in ? (wrap ? RST_DIV_FIELD : cnt + 1'b1) : cnt);
  // High for high_m1+1 of each period, raw level when dividing by one
  wire next_level = bypass ? src_level_in : (next_cnt <= cfg_in.high_m1);

  // Counter and output flops
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= RST_DIV_FIELD;
      clk_out <= 1'b0;
      tick_out <= 1'b0;
    end else begin
      cnt <= next_cnt;
      clk_out <= next_level;
      tick_out <= src_edge_in & wrap & ~load_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edges since the last wrap, for checking only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      edge_seen <= '0;
      period_seen <= 1'b0;
    end else if (load_in) begin
      edge_seen <= '0;
      period_seen <= 1'b0;
    end else if (src_edge_in) begin
      edge_seen <= wrap ? '0 : edge_seen + 1'b1;
      period_seen <= period_seen | wrap;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  div_period_a: assert property (
    (src_edge_in && wrap && !load_in && period_seen && $stable(cfg_in))
      |-> edge_seen == {1'b0, cfg_in.ratio_m1})
    else $error("output divider period differs from programmed ratio");

  div_phase_a: assert property (
    (load_in && cfg_in.phase <= cfg_in.ratio_m1) |=> cnt == $past(cfg_in.phase))
    else $error("output divider did not start at programmed phase");

  div_duty_a: assert property (
    (!bypass && $stable(cfg_in) && !load_in) |=> clk_out == (cnt <= $past(cfg_in.high_m1)))
    else $error("output level does not follow duty setting");

  div_bypass_a: assert property (
    (bypass && $stable(cfg_in)) |=> clk_out == $past(src_level_in))
    else $error("divide by one does not pass source level");

  div_wrap_c: cover property (src_edge_in && wrap && !bypass && period_seen);

endmodule

/* File: test/prd_clock_source.sv */
// Behavioural reference source, first clock input and oscillator on the pins
`timescale 1ns/1ps
module prd_clock_source #(
  parameter int REF_HALF = 60,
  parameter int DIST_HALF = 80,
  parameter int OSC_HALF = 100
) (
  output logic ref_out,
  output logic ref_comp_out,
  output logic dist_out,
  output logic osc_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Reference, slow enough for the detector at every tested ratio
  initial begin
    ref_out = 1'b0;
    #7;
    forever #(REF_HALF) ref_out = ~ref_out;
  end

  // Differential pair, complement always opposite
  assign ref_comp_out = ~ref_out;

  // First clock input, free running, unrelated phase
  initial begin
    dist_out = 1'b0;
    #13;
    forever #(DIST_HALF) dist_out = ~dist_out;
  end

  // Oscillator, free running, unrelated phase
  initial begin
    osc_out = 1'b0;
    #3;
    forever #(OSC_HALF) osc_out = ~osc_out;
  end
endmodule

/* File: test/test_prd_clock_core.sv */
// Self-checking bench for the reference divider and clock steering core
`timescale 1ns/1ps
module test_prd_clock_core;
  import prd_pkg::*;
  typedef struct {
    logic [11:0] a1;
    logic [31:0] d1;
    logic [11:0] a2;
    logic [31:0] d2;
    int kind;
    int per;
    int hi;
  } prd_row_t;

  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  prd_axi_req_t req = '0;
  prd_axi_rsp_t rsp;
  logic ref_p, ref_c, dist_p, osc_p, pfd_ref, pfd_fb, pump_up, pump_dn;
  logic [OUT_CNT-1:0] dist_clk;
  logic [31:0] rd;
  logic [1:0] resp;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int per, hi, cnt;

  // Rows: two writes, then watched period and high time in clock cycles
  prd_row_t rows [10] = '{
    '{12'h02c, 32'h0, 12'h030, 32'h2, 0, 12, 1},
    '{12'h02c, 32'h0, 12'h030, 32'h3, 0, 18, 1},
    '{12'h02c, 32'h0, 12'h030, 32'h0, 0, 6, 1},
    '{12'h02c, 32'h1, 12'h030, 32'h1, 0, 1542, 1},
    '{12'h114, 32'h0, 12'h13c, 32'h0004_0104, 8, 50, 20},
    '{12'h114, 32'h1, 12'h120, 32'h0, 1, 8, 4},
    '{12'h114, 32'h0, 12'h120, 32'h0, 1, 10, 5},
    '{12'h114, 32'h1, 12'h120, 32'h2, 1, 24, 8},
    '{12'h114, 32'h1, 12'h120, 32'h1f, 1, 256, 8},
    '{12'h114, 32'h1, 12'h120, 32'h103, 1, 32, 16}
  };

  ////////////////////////////////////////////////////////////////////////////
  // Clock and cycle ceiling
  always #10 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      give_verdict();
    end
  end

  // Pin sources and the core
  prd_clock_source i_src (
    .ref_out(ref_p),
    .ref_comp_out(ref_c),
    .dist_out(dist_p),
    .osc_out(osc_p)
  );

  prd_clock_core i_dut (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .axi_in(req),
    .axi_out(rsp),
    .reference_input_in(ref_p),
    .reference_input_complement_in(ref_c),
    .distribution_clock_input_in(dist_p),
    .oscillator_feedback_input_in(osc_p),
    .pfd_ref_out(pfd_ref),
    .pfd_fb_out(pfd_fb),
    .pump_up_out(pump_up),
    .pump_down_out(pump_dn),
    .dist_clk_out(dist_clk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task give_verdict();
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One register bus transfer, ready sampled just before each rising edge
  task axi(input bit wr, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic [1:0] r);
    bit aw_t, w_t, ar_t, done;
    int n;
    done = 0;
    r = 2'h3;
    q = 32'h0;
    @(posedge clk_in);
    if (wr) begin
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
    end else begin
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
    end
    for (n = 0; n < 50 && !done; n++) begin
      @(negedge clk_in);
      aw_t = req.awvalid && rsp.awready === 1'b1;
      w_t = req.wvalid && rsp.wready === 1'b1;
      ar_t = req.arvalid && rsp.arready === 1'b1;
      done = wr ? rsp.bvalid === 1'b1 : rsp.rvalid === 1'b1;
      if (done) begin
        r = wr ? rsp.bresp : rsp.rresp;
        q = rsp.rdata;
      end
      @(posedge clk_in);
      if (aw_t) req.awvalid <= 1'b0;
      if (w_t) req.wvalid <= 1'b0;
      if (ar_t) req.arvalid <= 1'b0;
      if (done) req.bready <= 1'b0;
      if (done) req.rready <= 1'b0;
    end
    check("bus_answer", done, 1'b1);
  endtask

  task wreg(input logic [11:0] a, input logic [31:0] d);
    axi(1'b1, a, d, rd, resp);
    check("bresp", resp, RESP_OKAY);
  endtask

  // Period and high time between the second and third event
  task measure(input int kind, output int p, output int h);
    int n, k, t1;
    logic prev, cur;
    k = 0;
    p = 0;
    h = 0;
    t1 = 0;
    prev = 1'b1;
    for (n = 0; n < 6000 && k < 3; n++) begin
      @(negedge clk_in);
      cur = kind ? dist_clk[kind - 1] : pfd_ref;
      if (cur === 1'b1 && (kind == 0 || prev === 1'b0)) begin
        k++;
        if (k == 2) t1 = n;
        if (k == 3) p = n - t1;
      end
      if (k == 2 && cur === 1'b1) h++;
      prev = cur;
    end
  endtask

  // Loop pulses in 100 cycles: feedback only, or any loop output
  task count(input int kind, output int c);
    c = 0;
    repeat (100) begin
      @(negedge clk_in);
      if (kind == 0 && pfd_fb === 1'b1) c++;
      if (kind == 1 && (pfd_ref | pfd_fb | pump_up | pump_dn) !== 1'b0) c++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    axi(1'b0, 12'h114, 32'h0, rd, resp);
    check("select", rd, 32'h1);
    axi(1'b0, 12'h030, 32'h0, rd, resp);
    check("ref_lower", rd, 32'h0);
    axi(1'b0, 12'h140, 32'h0, rd, resp);
    check("loop_on", rd, 32'h1);
    axi(1'b0, 12'h000, 32'h0, rd, resp);
    check("unmapped_resp", resp, RESP_SLVERR);
    check("unmapped_data", rd, 32'h0);
    axi(1'b1, 12'h144, 32'h5, rd, resp);
    check("status_write", resp, RESP_SLVERR);
    $display("Test reset and map done");
    foreach (rows[i]) begin
      wreg(rows[i].a1, rows[i].d1);
      wreg(rows[i].a2, rows[i].d2);
      measure(rows[i].kind, per, hi);
      check("period", per, rows[i].per);
      check("high", hi, rows[i].hi);
      $display("Test row %0d done", i);
    end
    // Widest divide value kept in both halves
    wreg(12'h02c, 32'h3f);
    wreg(12'h030, 32'hff);
    axi(1'b0, 12'h02c, 32'h0, rd, resp);
    check("ref_upper", rd, 32'h3f);
    axi(1'b0, 12'h030, 32'h0, rd, resp);
    check("ref_lower", rd, 32'hff);
    axi(1'b0, 12'h13c, 32'h0, rd, resp);
    check("div_cfg", rd, 32'h0004_0104);
    count(0, cnt);
    check("fb_pulses", cnt, 32'd10);
    $display("Test feedback done");
    wreg(12'h140, 32'h0);
    count(1, cnt);
    check("loop_off", cnt, 32'd0);
    measure(1, per, hi);
    check("dist_running", per, 32'd32);
    $display("Test loop off done");
    wreg(12'h114, 32'h0);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    axi(1'b0, 12'h114, 32'h0, rd, resp);
    check("select_again", rd, 32'h1);
    axi(1'b0, 12'h140, 32'h0, rd, resp);
    check("loop_again", rd, 32'h1);
    $display("Test second reset done");
    give_verdict();
  end
endmodule
